// ==== verilog/fbi_pkg.sv ====
// Constants, register map and operation codes of the flash bus host controller
package fbi_pkg;
	// Clock rate
	localparam int CLK_MHZ = 25;
	// Pin timing, in ns
	localparam int T_WRITE_PULSE_NS = 60;
	localparam int T_RANDOM_ACC_NS = 120;
	localparam int T_PAGE_ACC_NS = 40;
	localparam int T_RESET_PULSE_MIN_NS = 200;
	localparam int T_RESET_REC_NS = 400;
	localparam int T_ABORT_REC_NS = 2000;
	// Least times round up to whole cycles
	localparam logic [7:0] WP_CYC = 8'((T_WRITE_PULSE_NS * CLK_MHZ + 999) / 1000);
	localparam logic [7:0] ACC_CYC = 8'((T_RANDOM_ACC_NS * CLK_MHZ + 999) / 1000);
	localparam logic [7:0] PAGE_CYC = 8'((T_PAGE_ACC_NS * CLK_MHZ + 999) / 1000);
	localparam logic [7:0] RST_CYC = 8'((T_RESET_PULSE_MIN_NS * CLK_MHZ + 999) / 1000);
	localparam logic [7:0] REC_CYC =
		8'(((T_ABORT_REC_NS > T_RESET_REC_NS ? T_ABORT_REC_NS : T_RESET_REC_NS)
		* CLK_MHZ + 999) / 1000);
	// Register byte offsets
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_ADDR = 8'h04;
	localparam logic [7:0] REG_WDATA = 8'h08;
	localparam logic [7:0] REG_STATUS = 8'h0c;
	localparam logic [7:0] REG_RDATA0 = 8'h10;
	localparam logic [7:0] REG_LAST = 8'h1c;
	// CTRL fields
	localparam int CTRL_START = 0;
	localparam int CTRL_OP_LSB = 1;
	localparam int CTRL_WP_LEVEL = 4;
	localparam int CTRL_CE_STROBE = 5;
	// STATUS fields
	localparam int STAT_BUSY = 0;
	localparam int STAT_DONE = 1;
	localparam int STAT_IDMODE = 2;
	localparam int STAT_BANK_B = 3;
	localparam int STAT_BLOCK_LSB = 4;
	localparam int STAT_PROT = 9;
	localparam int STAT_LOCK = 10;
	// Operation codes
	localparam logic [2:0] OP_WRITE = 3'h0;
	localparam logic [2:0] OP_READ = 3'h1;
	localparam logic [2:0] OP_PAGE = 3'h2;
	localparam logic [2:0] OP_CMD = 3'h3;
	localparam logic [2:0] OP_RESET = 3'h4;
	// Command bus values
	localparam logic [19:0] UNLOCK1_ADDR = 20'h00555;
	localparam logic [15:0] UNLOCK1_DATA = 16'h00aa;
	localparam logic [19:0] UNLOCK2_ADDR = 20'h002aa;
	localparam logic [15:0] UNLOCK2_DATA = 16'h0055;
	localparam logic [7:0] CMD_IDENT = 8'h90;
	localparam logic [7:0] CMD_ARRAY = 8'hf0;
	// Array map
	localparam logic [19:0] BANK_B_BASE = 20'h40000;
	localparam logic [19:0] PARAM_TOP = 20'h08000;
	localparam logic [4:0] MAIN_A_FIRST = 5'h08;
	localparam logic [4:0] BANK_B_OFS = 5'h08;
	// AXI responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// Pin sequencer states
	typedef enum logic [3:0] {
		FBI_IDLE, FBI_WSETUP, FBI_WSTROBE, FBI_WRELEASE, FBI_WHOLD, FBI_WEND,
		FBI_RACC, FBI_REND, FBI_RSTLOW, FBI_RSTREC
	} fbi_state_t;
endpackage

// ==== verilog/fbi_wait_timer.sv ====
// Down-counter that times strobe widths and access waits
`timescale 1ns/1ps
module fbi_wait_timer (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Load and status
	input wire logic load,
	input wire logic [7:0] cycles,
	output logic expired
);
	logic [7:0] count;

	// Counts down from the loaded value, stops at zero
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			count <= 8'h00;
		end else if (load) begin
			count <= cycles;
		end else if (count != 8'h00) begin
			count <= count - 8'h01;
		end
	end

	// A load in progress never reads as expired
	assign expired = (count == 8'h00) && !load;
endmodule // fbi_wait_timer

// ==== verilog/fbi_flash_host.sv ====
// AXI4-Lite controlled host that drives a dual-bank NOR flash over its pins
`timescale 1ns/1ps
module fbi_flash_host (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// AXI4-Lite write channels
	input wire logic [7:0] awaddr,
	input wire logic [2:0] awprot,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	// AXI4-Lite read channels
	input wire logic [7:0] araddr,
	input wire logic [2:0] arprot,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	// Flash pins
	output logic [19:0] word_address_bus,
	output logic [15:0] data_lines_out,
	output logic data_lines_oe,
	input wire logic [15:0] data_lines_in,
	output logic chip_select_n,
	output logic read_gate_n,
	output logic write_strobe_n,
	output logic reset_powerdown_n,
	output logic write_lock_n
);
	fbi_pkg::fbi_state_t state;
	logic [19:0] addr_reg;
	logic [15:0] wdata_reg;
	logic [2:0] op_reg;
	logic ce_strobe;
	logic start_req;
	logic done_flag;
	logic done_pulse;
	logic identifier_mode;
	logic protected_flag;
	logic locked_flag;
	logic [1:0] step;
	logic [1:0] page_word_select;
	logic [15:0] page_buf [4];
	logic timer_load;
	logic [7:0] timer_cycles;
	logic timer_expired;
	logic wr_go;
	logic [31:0] wmask;
	logic [31:0] status_word;
	logic bank_b;
	logic [4:0] block_num;

	// Offset decode shared by both channels
	function automatic logic addr_mapped(input logic [7:0] a);
		return (a[1:0] == 2'h0) && (a <= fbi_pkg::REG_LAST);
	endfunction

	// Block decode of the bottom-boot map
	function automatic logic [4:0] block_of(input logic [19:0] a);
		if (a >= fbi_pkg::BANK_B_BASE) begin
			return a[19:15] - fbi_pkg::BANK_B_OFS;
		end else if (a < fbi_pkg::PARAM_TOP) begin
			return {2'h0, a[14:12]};
		end else begin
			return fbi_pkg::MAIN_A_FIRST + {2'h0, a[17:15]} - 5'h01;
		end
	endfunction

	assign bank_b = addr_reg >= fbi_pkg::BANK_B_BASE;
	assign block_num = block_of(addr_reg);

	// Byte lanes from the write strobes
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_mask
			assign wmask[gi*8 +: 8] = {8{wstrb[gi]}};
		end
	endgenerate

	fbi_wait_timer u_timer (
		.aclk(aclk),
		.aresetn(aresetn),
		.load(timer_load),
		.cycles(timer_cycles),
		.expired(timer_expired)
	);

	// Address and data are taken together, one write at a time
	assign wr_go = awvalid && wvalid && !awready && !bvalid;

	// Write channel handshake and response
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready <= 1'b0;
			wready <= 1'b0;
			bvalid <= 1'b0;
			bresp <= fbi_pkg::RESP_OKAY;
		end else begin
			awready <= wr_go;
			wready <= wr_go;
			if (awready) begin
				bvalid <= 1'b1;
				bresp <= addr_mapped(awaddr) ? fbi_pkg::RESP_OKAY : fbi_pkg::RESP_SLVERR;
			end else if (bready) begin
				bvalid <= 1'b0;
			end
		end
	end

	// Software registers; a start while busy is dropped
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			addr_reg <= 20'h00000;
			wdata_reg <= 16'h0000;
			op_reg <= fbi_pkg::OP_READ;
			ce_strobe <= 1'b0;
			write_lock_n <= 1'b1;
			start_req <= 1'b0;
		end else begin
			start_req <= 1'b0;
			if (awready) begin
				unique case (awaddr)
					fbi_pkg::REG_CTRL: begin
						if (wstrb[0]) begin
							op_reg <= wdata[fbi_pkg::CTRL_OP_LSB +: 3];
							write_lock_n <= wdata[fbi_pkg::CTRL_WP_LEVEL];
							ce_strobe <= wdata[fbi_pkg::CTRL_CE_STROBE];
							start_req <= wdata[fbi_pkg::CTRL_START] && state == fbi_pkg::FBI_IDLE;
						end
					end
					fbi_pkg::REG_ADDR: begin
						addr_reg <= 20'(({12'h000, addr_reg} & ~wmask) | (wdata & wmask));
					end
					fbi_pkg::REG_WDATA: begin
						wdata_reg <= 16'(({16'h0000, wdata_reg} & ~wmask) | (wdata & wmask));
					end
					default: begin
					end
				endcase
			end
		end
	end

	// Completion flag: a finish in the same cycle as a new start wins
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			done_flag <= 1'b0;
		end else if (done_pulse) begin
			done_flag <= 1'b1;
		end else if (start_req) begin
			done_flag <= 1'b0;
		end
	end

	always_comb begin
		status_word = 32'h00000000;
		status_word[fbi_pkg::STAT_BUSY] = state != fbi_pkg::FBI_IDLE;
		status_word[fbi_pkg::STAT_DONE] = done_flag;
		status_word[fbi_pkg::STAT_IDMODE] = identifier_mode;
		status_word[fbi_pkg::STAT_BANK_B] = bank_b;
		status_word[fbi_pkg::STAT_BLOCK_LSB +: 5] = block_num;
		status_word[fbi_pkg::STAT_PROT] = protected_flag;
		status_word[fbi_pkg::STAT_LOCK] = locked_flag;
	end

	// Read channel; data is sampled at the address handshake
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready <= 1'b0;
			rvalid <= 1'b0;
			rdata <= 32'h00000000;
			rresp <= fbi_pkg::RESP_OKAY;
		end else begin
			arready <= arvalid && !arready && !rvalid;
			if (arready) begin
				rvalid <= 1'b1;
				rresp <= addr_mapped(araddr) ? fbi_pkg::RESP_OKAY : fbi_pkg::RESP_SLVERR;
				if (araddr >= fbi_pkg::REG_RDATA0 && addr_mapped(araddr)) begin
					rdata <= {16'h0000, page_buf[araddr[3:2]]};
				end else begin
					unique case (araddr)
						fbi_pkg::REG_CTRL: rdata <= {26'h0, ce_strobe, write_lock_n, op_reg, 1'b0};
						fbi_pkg::REG_ADDR: rdata <= {12'h000, addr_reg};
						fbi_pkg::REG_WDATA: rdata <= {16'h0000, wdata_reg};
						fbi_pkg::REG_STATUS: rdata <= status_word;
						default: rdata <= 32'h00000000;
					endcase
				end
			end else if (rready) begin
				rvalid <= 1'b0;
			end
		end
	end

	// Pin sequencer; every pin is a flop and changes one step at a time,
	// so no strobe pulse is ever shorter than a full 40 ns cycle
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state <= fbi_pkg::FBI_IDLE;
			word_address_bus <= 20'h00000;
			data_lines_out <= 16'h0000;
			data_lines_oe <= 1'b0;
			chip_select_n <= 1'b1;
			read_gate_n <= 1'b1;
			write_strobe_n <= 1'b1;
			reset_powerdown_n <= 1'b1;
			step <= 2'h0;
			page_word_select <= 2'h0;
			timer_load <= 1'b0;
			timer_cycles <= 8'h00;
			done_pulse <= 1'b0;
			identifier_mode <= 1'b0;
			protected_flag <= 1'b0;
			locked_flag <= 1'b0;
			for (int i = 0; i < 4; i++) begin
				page_buf[i] <= 16'h0000;
			end
		end else begin
			timer_load <= 1'b0;
			done_pulse <= 1'b0;
			unique case (state)
				fbi_pkg::FBI_IDLE: begin
					step <= (op_reg == fbi_pkg::OP_CMD) ? 2'h0 : 2'h2;
					page_word_select <= 2'h0;
					if (start_req) begin
						unique case (op_reg)
							fbi_pkg::OP_WRITE, fbi_pkg::OP_CMD: begin
								state <= fbi_pkg::FBI_WSETUP;
							end
							fbi_pkg::OP_RESET: begin
								reset_powerdown_n <= 1'b0;
								timer_load <= 1'b1;
								timer_cycles <= fbi_pkg::RST_CYC;
								state <= fbi_pkg::FBI_RSTLOW;
							end
							default: begin
								// Gate falls with select and address in the same cycle
								word_address_bus <= {addr_reg[19:2], 2'h0};
								if (op_reg == fbi_pkg::OP_READ || identifier_mode) begin
									word_address_bus <= addr_reg;
								end
								chip_select_n <= 1'b0;
								read_gate_n <= 1'b0;
								timer_load <= 1'b1;
								timer_cycles <= fbi_pkg::ACC_CYC;
								state <= fbi_pkg::FBI_RACC;
							end
						endcase
					end
				end
				fbi_pkg::FBI_WSETUP: begin
					// Address and data settle before either strobe falls
					unique case (step)
						2'h0: begin
							word_address_bus <= fbi_pkg::UNLOCK1_ADDR;
							data_lines_out <= fbi_pkg::UNLOCK1_DATA;
						end
						2'h1: begin
							word_address_bus <= fbi_pkg::UNLOCK2_ADDR;
							data_lines_out <= fbi_pkg::UNLOCK2_DATA;
						end
						default: begin
							word_address_bus <= addr_reg;
							data_lines_out <= wdata_reg;
						end
					endcase
					data_lines_oe <= 1'b1;
					read_gate_n <= 1'b1;
					state <= fbi_pkg::FBI_WSTROBE;
				end
				fbi_pkg::FBI_WSTROBE: begin
					// Held strobe falls first; the timing strobe falls later
					if (ce_strobe) begin
						write_strobe_n <= 1'b0;
					end else begin
						chip_select_n <= 1'b0;
					end
					timer_load <= 1'b1;
					timer_cycles <= fbi_pkg::WP_CYC;
					state <= fbi_pkg::FBI_WRELEASE;
				end
				fbi_pkg::FBI_WRELEASE: begin
					if (ce_strobe) begin
						chip_select_n <= 1'b0;
					end else begin
						write_strobe_n <= 1'b0;
					end
					if (!timer_load && timer_expired && !(ce_strobe ? chip_select_n : write_strobe_n)) begin
						// Timing strobe rises first; data still driven
						if (ce_strobe) begin
							chip_select_n <= 1'b1;
						end else begin
							write_strobe_n <= 1'b1;
						end
						state <= fbi_pkg::FBI_WHOLD;
					end
				end
				fbi_pkg::FBI_WHOLD: begin
					chip_select_n <= 1'b1;
					write_strobe_n <= 1'b1;
					state <= fbi_pkg::FBI_WEND;
				end
				fbi_pkg::FBI_WEND: begin
					data_lines_oe <= 1'b0;
					if (step != 2'h2) begin
						step <= step + 2'h1;
						state <= fbi_pkg::FBI_WSETUP;
					end else begin
						// Only 90h at the unlock address after unlock enters
						// identifier mode; F0h or anything else leaves it
						identifier_mode <= op_reg == fbi_pkg::OP_CMD
							&& addr_reg == fbi_pkg::UNLOCK1_ADDR
							&& wdata_reg[7:0] == fbi_pkg::CMD_IDENT;
						done_pulse <= 1'b1;
						state <= fbi_pkg::FBI_IDLE;
					end
				end
				fbi_pkg::FBI_RACC: begin
					if (!timer_load && timer_expired) begin
						page_buf[page_word_select] <= data_lines_in;
						if (identifier_mode && page_word_select == 2'h0) begin
							protected_flag <= data_lines_in[0];
							locked_flag <= data_lines_in[1];
						end
						if (op_reg == fbi_pkg::OP_PAGE && !identifier_mode
							&& page_word_select != 2'h3) begin
							// Next word of the same page at page speed
							page_word_select <= page_word_select + 2'h1;
							word_address_bus[1:0] <= page_word_select + 2'h1;
							timer_load <= 1'b1;
							timer_cycles <= fbi_pkg::PAGE_CYC;
						end else begin
							read_gate_n <= 1'b1;
							state <= fbi_pkg::FBI_REND;
						end
					end
				end
				fbi_pkg::FBI_REND: begin
					chip_select_n <= 1'b1;
					done_pulse <= 1'b1;
					state <= fbi_pkg::FBI_IDLE;
				end
				fbi_pkg::FBI_RSTLOW: begin
					if (!timer_load && timer_expired) begin
						reset_powerdown_n <= 1'b1;
						identifier_mode <= 1'b0;
						timer_load <= 1'b1;
						timer_cycles <= fbi_pkg::REC_CYC;
						state <= fbi_pkg::FBI_RSTREC;
					end
				end
				fbi_pkg::FBI_RSTREC: begin
					if (!timer_load && timer_expired) begin
						done_pulse <= 1'b1;
						state <= fbi_pkg::FBI_IDLE;
					end
				end
				default: begin
					state <= fbi_pkg::FBI_IDLE;
				end
			endcase
		end
	end
endmodule // fbi_flash_host

// ==== tb/fbi_flash_host_monitor.sv ====
// Concurrent checks on the pins and bus handshakes of the flash host
`timescale 1ns/1ps
module fbi_flash_host_monitor (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Register bus handshakes
	input wire logic awready,
	input wire logic bvalid,
	input wire logic rvalid,
	input wire logic rready,
	input wire logic [31:0] rdata,
	// Flash pins
	input wire logic [19:0] word_address_bus,
	input wire logic [15:0] data_lines_out,
	input wire logic data_lines_oe,
	input wire logic chip_select_n,
	input wire logic read_gate_n,
	input wire logic write_strobe_n,
	input wire logic reset_powerdown_n
);
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	logic [7:0] rec_cnt;
	// Cycles since the reset pin rose; saturates so idle spells never wrap
	always_ff @(posedge aclk) begin
		if (!aresetn) rec_cnt <= 8'hff;
		else if (!reset_powerdown_n) rec_cnt <= 8'h00;
		else if (rec_cnt != 8'hff) rec_cnt <= rec_cnt + 8'h01;
	end
	a_gate_in_write: assert property (!write_strobe_n |-> read_gate_n)
		else $error("read gate low during write strobe");
	a_drive_vs_gate: assert property (data_lines_oe |-> read_gate_n)
		else $error("host drives data while gate is low");
	a_gate_needs_cs: assert property (!read_gate_n |-> !chip_select_n)
		else $error("read gate low without chip select");
	a_addr_steady: assert property (!write_strobe_n |-> $stable(word_address_bus))
		else $error("address moved during write strobe");
	a_data_hold: assert property (!write_strobe_n && !chip_select_n && data_lines_oe
		|=> data_lines_oe && $stable(data_lines_out))
		else $error("write data not held across rising strobe");
	a_strobe_width: assert property ($fell(write_strobe_n) |-> !write_strobe_n [*3])
		else $error("write strobe pulse too short");
	a_reset_width: assert property ($fell(reset_powerdown_n) |-> !reset_powerdown_n [*6])
		else $error("reset pulse shorter than minimum");
	a_reset_recovery: assert property (!chip_select_n |-> rec_cnt >= 8'h32)
		else $error("chip selected too soon after reset pin rose");
	a_write_answer: assert property (awready |=> bvalid)
		else $error("no write response after address taken");
	a_read_holds: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
		else $error("read data dropped before rready");
endmodule // fbi_flash_host_monitor
bind fbi_flash_host fbi_flash_host_monitor u_mon (
	.aclk, .aresetn, .awready, .bvalid, .rvalid, .rready, .rdata,
	.word_address_bus, .data_lines_out, .data_lines_oe, .chip_select_n,
	.read_gate_n, .write_strobe_n, .reset_powerdown_n
);

// ==== tb/fbi_flash_model.sv ====
// Behavioural dual-bank flash seen from its pins
`timescale 1ns/1ps
module fbi_flash_model #(
	parameter logic [15:0] MAKER_CODE = 16'h1357, // Arbitrary value
	parameter logic [15:0] DEVICE_CODE = 16'h2468, // Arbitrary value
	parameter int ACC_NS = 0
) (
	// Pins from the host
	input wire logic [19:0] word_address_bus,
	input wire logic [15:0] data_lines_out,
	input wire logic data_lines_oe,
	input wire logic chip_select_n,
	input wire logic read_gate_n,
	input wire logic write_strobe_n,
	input wire logic reset_powerdown_n,
	// Data back to the host
	output logic [15:0] data_lines_in
);
	logic [19:0] lat_addr = 20'h0;
	logic [1:0] unlock_step = 2'h0;
	logic identifier_mode = 1'b0; // Starts in array read
	logic [15:0] val;
	logic [15:0] held = 16'h0;
	wire wr_act = !chip_select_n && !write_strobe_n && read_gate_n && reset_powerdown_n;
	wire drive = !chip_select_n && !read_gate_n && reset_powerdown_n;
	// Address taken on the later falling strobe
	always @(posedge wr_act) lat_addr = word_address_bus;
	// Command taken on the earlier rising strobe; reset pin clears it all
	always @(negedge wr_act or negedge reset_powerdown_n) begin
		if (!reset_powerdown_n) begin
			unlock_step = 2'h0;
			identifier_mode = 1'b0;
		end else if (data_lines_oe && data_lines_out[7:0] == 8'hf0) begin
			unlock_step = 2'h0;
			identifier_mode = 1'b0;
		end else if (unlock_step == 2'h0 && lat_addr == 20'h00555 && data_lines_out == 16'h00aa)
			unlock_step = 2'h1;
		else if (unlock_step == 2'h1 && lat_addr == 20'h002aa && data_lines_out == 16'h0055)
			unlock_step = 2'h2;
		else if (unlock_step == 2'h2 && lat_addr == 20'h00555 && data_lines_out == 16'h0090) begin
			unlock_step = 2'h0;
			identifier_mode = 1'b1;
		end else begin
			unlock_step = 2'h0;
			identifier_mode = 1'b0;
		end
	end
	// Read value; identifier places are single words with no page
	always_comb begin
		if (!identifier_mode) val = word_address_bus[15:0] ^ 16'h5a3c;
		else if (word_address_bus[7:0] == 8'h00) val = MAKER_CODE;
		else if (word_address_bus[7:0] == 8'h01) val = DEVICE_CODE;
		else if (word_address_bus[7:0] == 8'h02) val = {14'h0, word_address_bus[13:12]};
		else val = 16'h0000;
	end
	// Released lines show the inverse of the last word, never a stale copy
	always @(drive or val) if (drive) held = ~val;
	assign #(ACC_NS) data_lines_in = drive ? val : held;
endmodule // fbi_flash_model

// ==== tb/tb_top.sv ====
// Register-level bench for the flash host against the flash model
`timescale 1ns/1ps
module tb_top;
	localparam logic [15:0] MAKER = 16'h1357; // Arbitrary value
	localparam logic [15:0] DEVICE = 16'h2468; // Arbitrary value
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [7:0] awaddr = 8'h0, araddr = 8'h0;
	logic [2:0] awprot = 3'h0, arprot = 3'h0;
	logic [3:0] wstrb = 4'hf;
	logic [31:0] wdata = 32'h0, rdata, v;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic awready, wready, bvalid, arready, rvalid, data_lines_oe;
	logic chip_select_n, read_gate_n, write_strobe_n, reset_powerdown_n, write_lock_n;
	logic [1:0] bresp, rresp, r;
	logic [19:0] word_address_bus;
	logic [15:0] data_lines_out, data_lines_in;
	logic [19:0] blk_a [9] = '{20'h00000, 20'h00fff, 20'h07000, 20'h08000, 20'h3ffff,
		20'h40000, 20'h47fff, 20'hf8000, 20'hfffff};
	int n_mismatch = 0;
	int cmp_count = 0;
	int k;
	always #20 aclk = ~aclk;
	fbi_flash_host uut (.aclk, .aresetn, .awaddr, .awprot, .awvalid, .awready, .wdata, .wstrb,
		.wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arprot, .arvalid, .arready,
		.rdata, .rresp, .rvalid, .rready, .word_address_bus, .data_lines_out, .data_lines_oe,
		.data_lines_in, .chip_select_n, .read_gate_n, .write_strobe_n, .reset_powerdown_n,
		.write_lock_n);
	// Slow enough to test the wait, quick enough for page words
	fbi_flash_model #(.MAKER_CODE(MAKER), .DEVICE_CODE(DEVICE), .ACC_NS(30)) u_flash (
		.word_address_bus, .data_lines_out, .data_lines_oe, .chip_select_n, .read_gate_n,
		.write_strobe_n, .reset_powerdown_n, .data_lines_in);
	task automatic print_verdict;
		$display("Comparisons %0d mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	task automatic to;
		n_mismatch++;
		$display("[FAIL] %0t wait ran out", $time);
		print_verdict();
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	// One write; the extra edge keeps back-to-back calls from clashing
	task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] s);
		int i;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (i = 0; i < 50; i++) begin
			@(posedge aclk);
			if (awready === 1'b1) awvalid <= 1'b0;
			if (wready === 1'b1) wvalid <= 1'b0;
			if (bvalid === 1'b1) break;
		end
		bready <= 1'b0;
		s = bresp;
		@(posedge aclk);
		if (i == 50) to();
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] s);
		int i;
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (i = 0; i < 50; i++) begin
			@(posedge aclk);
			if (arready === 1'b1) arvalid <= 1'b0;
			if (rvalid === 1'b1) break;
		end
		rready <= 1'b0;
		d = rdata;
		s = rresp;
		@(posedge aclk);
		if (i == 50) to();
	endtask
	task automatic rdchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		logic [31:0] d;
		logic [1:0] s;
		rd(a, d, s);
		chk(d & m, e);
	endtask
	// Load address and data, start, then poll done
	task automatic fop(input logic [19:0] a, input logic [15:0] d, input logic [31:0] c);
		int i;
		wr(8'h04, {12'h0, a}, r);
		wr(8'h08, {16'h0, d}, r);
		wr(8'h00, c, r);
		for (i = 0; i < 100; i++) begin
			rd(8'h0c, v, r);
			if (v[1] === 1'b1) break;
		end
		if (i == 100) to();
	endtask
	function automatic logic [15:0] arr(input logic [19:0] a);
		return a[15:0] ^ 16'h5a3c;
	endfunction
	function automatic logic [31:0] exp_blk(input logic [19:0] a);
		if (a >= 20'h40000) return {23'h0, 5'((a - 20'h40000) >> 15), 4'h8};
		if (a < 20'h08000) return {23'h0, 5'(a >> 12), 4'h0};
		return {23'h0, 5'(7 + (a >> 15)), 4'h0};
	endfunction
	initial begin
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		chk({29'h0, reset_powerdown_n, chip_select_n, data_lines_oe}, 32'h6);
		rdchk(8'h00, 32'hffffffff, 32'h12);
		rd(8'h20, v, r);
		chk({v[29:0], r}, 32'h2);
		wr(8'h40, 32'h0, r);
		chk({30'h0, r}, 32'h2);
		// Bank and block numbering over the boundaries
		for (k = 0; k < 9; k++) begin
			wr(8'h04, {12'h0, blk_a[k]}, r);
			rdchk(8'h0c, 32'h1f8, exp_blk(blk_a[k]));
		end
		// Identifier readout, page request served as a single word
		fop(20'h00555, 16'h0090, 32'h17);
		rdchk(8'h0c, 32'h4, 32'h4);
		fop(20'h00000, 16'h0, 32'h15);
		rdchk(8'h10, 32'hffffffff, {16'h0, MAKER});
		rdchk(8'h14, 32'hffffffff, 32'h0);
		fop(20'h00001, 16'h0, 32'h13);
		rdchk(8'h10, 32'hffffffff, {16'h0, DEVICE});
		fop(20'h03002, 16'h0, 32'h13);
		rdchk(8'h10, 32'hffffffff, 32'h3);
		rdchk(8'h0c, 32'h600, 32'h600);
		// Back to array, then a four-word page
		fop(20'h12345, 16'h00f0, 32'h17);
		rdchk(8'h0c, 32'h4, 32'h0);
		fop(20'h00104, 16'h0, 32'h15);
		for (k = 0; k < 4; k++) rdchk(8'h10 + 8'(4 * k), 32'hffffffff, {16'h0, arr(20'h104 + k)});
		// Lone chip-select-timed write is no valid command
		fop(20'h00555, 16'h0090, 32'h17);
		fop(20'h00000, 16'h0000, 32'h31);
		fop(20'h00000, 16'h0, 32'h13);
		rdchk(8'h10, 32'hffffffff, {16'h0, arr(20'h0)});
		// Reset pulse with the write lock pulled low
		fop(20'h00555, 16'h0090, 32'h17);
		fop(20'h00000, 16'h0, 32'h09);
		chk({31'h0, write_lock_n}, 32'h0);
		fop(20'h00002, 16'h0, 32'h13);
		rdchk(8'h10, 32'hffffffff, {16'h0, arr(20'h2)});
		print_verdict();
	end
endmodule // tb_top
